// *** ddsl_fifo.sv ***
// ddsl_fifo: synchronous first-in first-out buffer with valid/ready on both sides
// assumes one clock, asynchronous active-high reset, read data taken from a register
`timescale 1ns/1ps
`default_nettype none

module ddsl_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic push;
  logic load;

  // the output register is an extra slot; full only speaks for the memory
  assign o_wr_ready = (count != FULL_COUNT);
  assign push = i_wr_valid && o_wr_ready;
  assign load = (count != '0) && (!o_rd_valid || i_rd_ready);

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_ptr <= '0;
    end else if (load) begin
      rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count <= '0;
    end else if (push && !load) begin
      count <= count + 1'b1;
    end else if (load && !push) begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else if (load) begin
      o_rd_valid <= 1'b1;
      o_rd_data <= mem[rd_ptr];
    end else if (i_rd_ready) begin
      o_rd_valid <= 1'b0;
    end
  end

endmodule : ddsl_fifo

`default_nettype wire

// *** ddsl_load_logic.sv ***
// ddsl_load_logic: serial load, address decode, input and dac registers of a dual converter
// assumes the host drives the serial clock, chip select and data; the serial
// clock only runs inside frames; strobes and straps are asynchronous pins
//
// Functional notes
// - shift one bit per rising clock, select low
// - select rise loads addressed input registers
// - wide variant uses last 18 bits
// - narrow variant uses last 16 bits
// - wide word: selects B17/B16, data B15..B0
// - narrow word: selects B15/B14, data B13..B0
// - selects decode none, A, B, both
// - low load strobe makes dac registers follow
// - clear with preset low forces zero
// - wide clear with preset high: 0x8000
// - narrow clear with preset high: 0x2000
// - power-on leaves input and dac registers zero
// - dac register code drives channel switches
// - load strobe asynchronous, level, active low

// ****************************************************************
// package
// ****************************************************************
package ddsl_pkg;

  localparam int SHIFT_W = 18;
  localparam int CODE_W = 16;
  localparam int FIFO_DEPTH = 16;

  // wide variant field positions
  localparam int WIDE_SEL_HI_POS = 17;
  localparam int WIDE_SEL_LO_POS = 16;
  localparam int WIDE_DATA_MSB = 15;
  // narrow variant field positions
  localparam int NARROW_SEL_HI_POS = 15;
  localparam int NARROW_SEL_LO_POS = 14;
  localparam int NARROW_DATA_MSB = 13;

  localparam logic [CODE_W-1:0] ZERO_CODE = 16'h0000;
  localparam logic [CODE_W-1:0] WIDE_MID_CODE = 16'h8000;
  localparam logic [CODE_W-1:0] NARROW_MID_CODE = 16'h2000;
  localparam logic [CODE_W-1:0] POWER_ON_CODE = 16'h0000;
  localparam logic [SHIFT_W-1:0] SHIFT_RESET = 18'h00000;

  typedef struct packed {
    logic channel_sel_hi;
    logic channel_sel_lo;
    logic [CODE_W-1:0] data;
  } ddsl_word_t;

  typedef struct packed {
    logic [CODE_W-1:0] chan_a;
    logic [CODE_W-1:0] chan_b;
  } ddsl_pair_t;

  typedef enum logic [1:0] {
    DDSL_SEL_NONE,
    DDSL_SEL_A,
    DDSL_SEL_B,
    DDSL_SEL_BOTH
  } ddsl_sel_t;

endpackage : ddsl_pkg

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// top module
// ****************************************************************
module ddsl_load_logic #(
  parameter bit WIDE = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_serial_clk,
  input wire logic i_chip_sel_n,
  input wire logic i_serial_data_in,
  input wire logic i_load_strobe_n,
  input wire logic i_clear_n,
  input wire logic i_preset_mid,
  input wire logic i_update_hold,
  output logic [15:0] o_dac_a_code,
  output logic [15:0] o_dac_b_code,
  output logic o_word_ready,
  output logic o_word_dropped
);

  // ****************************************************************
  // link domain: serial shift register
  // ****************************************************************
  logic [ddsl_pkg::SHIFT_W-1:0] shift_reg;

  // data is sampled on the host's own clock, so no synchroniser here
  always_ff @(posedge i_serial_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_reg <= ddsl_pkg::SHIFT_RESET;
    end else if (!i_chip_sel_n) begin
      shift_reg <= {shift_reg[ddsl_pkg::SHIFT_W-2:0], i_serial_data_in};
    end
  end

  // ****************************************************************
  // system domain: pin synchronisers
  // ****************************************************************
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic load_meta;
  logic load_sync_n;
  logic clear_meta;
  logic clear_sync_n;
  logic preset_meta;
  logic preset_sync;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= i_chip_sel_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      load_meta <= 1'b1;
      load_sync_n <= 1'b1;
    end else begin
      load_meta <= i_load_strobe_n;
      load_sync_n <= load_meta;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clear_meta <= 1'b1;
      clear_sync_n <= 1'b1;
    end else begin
      clear_meta <= i_clear_n;
      clear_sync_n <= clear_meta;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      preset_meta <= 1'b0;
      preset_sync <= 1'b0;
    end else begin
      preset_meta <= i_preset_mid;
      preset_sync <= preset_meta;
    end
  end

  // ****************************************************************
  // word capture at the chip select rise
  // ****************************************************************
  logic cs_rise;
  logic clear_active;
  ddsl_pkg::ddsl_word_t captured;
  ddsl_pkg::ddsl_word_t cap_word;
  logic cap_valid;
  logic fifo_wr_ready;

  assign cs_rise = cs_sync && !cs_prev;
  assign clear_active = !clear_sync_n;

  // the serial clock is still while select is high, so the shift register
  // is stable here and may be taken as a quasi-static word
  always_comb begin
    captured = '0;
    if (WIDE) begin
      captured.channel_sel_hi = shift_reg[ddsl_pkg::WIDE_SEL_HI_POS];
      captured.channel_sel_lo = shift_reg[ddsl_pkg::WIDE_SEL_LO_POS];
      captured.data = shift_reg[ddsl_pkg::WIDE_DATA_MSB:0];
    end else begin
      captured.channel_sel_hi = shift_reg[ddsl_pkg::NARROW_SEL_HI_POS];
      captured.channel_sel_lo = shift_reg[ddsl_pkg::NARROW_SEL_LO_POS];
      captured.data = {2'h0, shift_reg[ddsl_pkg::NARROW_DATA_MSB:0]};
    end
  end

  // a word finished during clear is thrown away
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cap_valid <= 1'b0;
      cap_word <= '0;
    end else begin
      cap_valid <= cs_rise && !clear_active;
      cap_word <= captured;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_word_dropped <= 1'b0;
    end else begin
      o_word_dropped <= cap_valid && !fifo_wr_ready;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_word_ready <= 1'b0;
    end else begin
      o_word_ready <= fifo_wr_ready;
    end
  end

  // ****************************************************************
  // word buffer
  // ****************************************************************
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  ddsl_pkg::ddsl_word_t fifo_rd_word;

  // hold stalls the drain so bursts back up; clear drains and discards
  assign fifo_rd_ready = !i_update_hold || clear_active;

  ddsl_fifo #(
    .WIDTH($bits(ddsl_pkg::ddsl_word_t)),
    .DEPTH(ddsl_pkg::FIFO_DEPTH)
  ) u_word_fifo (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_wr_valid(cap_valid),
    .o_wr_ready(fifo_wr_ready),
    .i_wr_data(cap_word),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(fifo_rd_ready),
    .o_rd_data(fifo_rd_word)
  );

  // ****************************************************************
  // address decode
  // ****************************************************************
  ddsl_pkg::ddsl_sel_t sel;
  logic write_a;
  logic write_b;
  logic apply;

  assign apply = fifo_rd_valid && fifo_rd_ready && !clear_active;

  always_comb begin
    sel = ddsl_pkg::DDSL_SEL_NONE;
    write_a = 1'b0;
    write_b = 1'b0;
    unique case ({fifo_rd_word.channel_sel_hi, fifo_rd_word.channel_sel_lo})
      2'b00: begin
        sel = ddsl_pkg::DDSL_SEL_NONE;
      end
      2'b01: begin
        sel = ddsl_pkg::DDSL_SEL_A;
      end
      2'b10: begin
        sel = ddsl_pkg::DDSL_SEL_B;
      end
      2'b11: begin
        sel = ddsl_pkg::DDSL_SEL_BOTH;
      end
    endcase
    unique case (sel)
      ddsl_pkg::DDSL_SEL_NONE: begin
        write_a = 1'b0;
        write_b = 1'b0;
      end
      ddsl_pkg::DDSL_SEL_A: begin
        write_a = apply;
      end
      ddsl_pkg::DDSL_SEL_B: begin
        write_b = apply;
      end
      ddsl_pkg::DDSL_SEL_BOTH: begin
        write_a = apply;
        write_b = apply;
      end
    endcase
  end

  // ****************************************************************
  // preset value
  // ****************************************************************
  logic [ddsl_pkg::CODE_W-1:0] preset_code;

  always_comb begin
    if (!preset_sync) begin
      preset_code = ddsl_pkg::ZERO_CODE;
    end else if (WIDE) begin
      preset_code = ddsl_pkg::WIDE_MID_CODE;
    end else begin
      preset_code = ddsl_pkg::NARROW_MID_CODE;
    end
  end

  // ****************************************************************
  // input registers
  // ****************************************************************
  ddsl_pkg::ddsl_pair_t input_regs;
  ddsl_pkg::ddsl_pair_t next_input_regs;

  always_comb begin
    next_input_regs = input_regs;
    if (clear_active) begin
      next_input_regs.chan_a = preset_code;
      next_input_regs.chan_b = preset_code;
    end else begin
      if (write_a) begin
        next_input_regs.chan_a = fifo_rd_word.data;
      end
      if (write_b) begin
        next_input_regs.chan_b = fifo_rd_word.data;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      input_regs <= {ddsl_pkg::POWER_ON_CODE, ddsl_pkg::POWER_ON_CODE};
    end else begin
      input_regs <= next_input_regs;
    end
  end

  // ****************************************************************
  // dac registers
  // ****************************************************************
  // follows the input registers one cycle late while the strobe is low;
  // a strobe held low permanently gives single-buffered operation
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dac_a_code <= ddsl_pkg::POWER_ON_CODE;
      o_dac_b_code <= ddsl_pkg::POWER_ON_CODE;
    end else if (clear_active) begin
      o_dac_a_code <= preset_code;
      o_dac_b_code <= preset_code;
    end else if (!load_sync_n) begin
      o_dac_a_code <= input_regs.chan_a;
      o_dac_b_code <= input_regs.chan_b;
    end
  end

endmodule : ddsl_load_logic

`default_nettype wire

// *** ddsl_load_logic_assertions.sv ***
// checker: port timing of the dac load logic on the system clock
// bound to every ddsl_load_logic instance by the testbench
`timescale 1ns/1ps
`default_nettype none

module ddsl_load_logic_assertions #(
  parameter bit WIDE = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_load_strobe_n,
  input wire logic i_clear_n,
  input wire logic i_preset_mid,
  input wire logic i_update_hold,
  input wire logic [15:0] o_dac_a_code,
  input wire logic [15:0] o_dac_b_code,
  input wire logic o_word_ready,
  input wire logic o_word_dropped
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic [15:0] mid;
  logic [4:0] sh_ld;
  logic [4:0] sh_cl;
  assign mid = WIDE ? 16'h8000 : 16'h2000;
  // pin history: a dac change needs a low strobe or clear a few edges back
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sh_ld <= 5'h1F;
      sh_cl <= 5'h1F;
    end else begin
      sh_ld <= {sh_ld[3:0], i_load_strobe_n};
      sh_cl <= {sh_cl[3:0], i_clear_n};
    end
  end
  a_clear_zero: assert property ((!i_clear_n && !i_preset_mid)[*5] |->
    o_dac_a_code == 16'h0000 && o_dac_b_code == 16'h0000) else $error("clear zero missed");
  a_clear_mid: assert property ((!i_clear_n && i_preset_mid)[*5] |->
    o_dac_a_code == mid && o_dac_b_code == mid) else $error("clear midscale missed");
  a_strobe_hold: assert property ((i_load_strobe_n && i_clear_n)[*5] |->
    $stable(o_dac_a_code) && $stable(o_dac_b_code)) else $error("dac moved while held");
  a_change_cause: assert property (!$stable({o_dac_a_code, o_dac_b_code}) |->
    !(&sh_ld[4:1] && &sh_cl[4:1])) else $error("dac moved without cause");
  a_clear_stable: assert property ((!i_clear_n && $stable(i_preset_mid))[*5] |->
    $stable(o_dac_a_code) && $stable(o_dac_b_code)) else $error("dac moved in clear");
  a_drop_pulse: assert property (o_word_dropped |=> !o_word_dropped)
    else $error("drop pulse too long");
  a_drop_full: assert property (o_word_dropped |-> !$past(o_word_ready, 3))
    else $error("drop while not full");
  a_drop_hold: assert property (o_word_dropped |-> $past(i_update_hold, 3))
    else $error("drop while draining");
endmodule : ddsl_load_logic_assertions

`default_nettype wire

// *** ddsl_host.sv ***
// host model: drives the three-wire serial link of the load logic
// its clock runs only inside frames, period 160 ns, free phase
`timescale 1ns/1ps
`default_nettype none

module ddsl_host (
  output logic o_serial_clk,
  output logic o_chip_sel_n,
  output logic o_serial_data
);
  initial begin
    o_serial_clk = 1'b0;
    o_chip_sel_n = 1'b1;
    o_serial_data = 1'b0;
  end
  // sends the low n bits of w, first bit the highest
  task automatic send(input logic [23:0] w, input int n);
    #37;
    o_chip_sel_n = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      o_serial_data = w[k];
      #80 o_serial_clk = 1'b1;
      #80 o_serial_clk = 1'b0;
    end
    #80 o_chip_sel_n = 1'b1;
    // released data line must not look like a held bit
    o_serial_data = ~o_serial_data;
  endtask : send
endmodule : ddsl_host

`default_nettype wire

// *** test_ddsl_load_logic.sv ***
// testbench: wide and narrow load logic fed by one host model
// compares dac codes, fill level and drops with a behavioural model
`timescale 1ns/1ps
`default_nettype none

module test_ddsl_load_logic;
  logic clk = 1'b0, rst = 1'b1, ld_n = 1'b1, clr_n = 1'b1, pre = 1'b0, hold = 1'b0;
  wire logic sclk, cs_n, serial_data_in;
  logic [15:0] a [2], b [2];
  logic rdy [2], drp [2];
  int ir [2][2], dr [2][2], n_mismatch = 0, checked = 0, nd [2] = '{0, 0};
  logic [23:0] acc [$];
  always #5 clk = ~clk;
  // both variants see the same frames, so each must drop exactly as often
  always @(posedge clk) begin
    for (int v = 0; v < 2; v++) begin
      if (drp[v] === 1'b1) nd[v]++;
    end
  end

  ddsl_host i_ddsl_host (.o_serial_clk(sclk), .o_chip_sel_n(cs_n), .o_serial_data(serial_data_in));
  for (genvar v = 0; v < 2; v++) begin : g_var
    ddsl_load_logic #(.WIDE(v == 0)) i_ddsl_load_logic (.i_clock(clk), .i_sys_rst(rst),
      .i_serial_clk(sclk), .i_chip_sel_n(cs_n), .i_serial_data_in(serial_data_in), .i_load_strobe_n(ld_n),
      .i_clear_n(clr_n), .i_preset_mid(pre), .i_update_hold(hold), .o_dac_a_code(a[v]),
      .o_dac_b_code(b[v]), .o_word_ready(rdy[v]), .o_word_dropped(drp[v]));
  end

  // ******************************
  // model and checks
  // ******************************
  task automatic apply(input logic [23:0] w);
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < 2; c++) begin
        if (v == 0 ? w[16 + c] : w[14 + c]) ir[v][c] = v == 0 ? int'(w[15:0]) : int'(w[13:0]);
      end
    end
  endtask : apply
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic frame(input logic [23:0] w);
    i_ddsl_host.send(w, 24);
    step(20);
    if (!hold) apply(w);
    else if (acc.size() < 17) acc.push_back(w);
    if (!ld_n) dr = ir;
  endtask : frame
  task automatic strobe;
    ld_n = 1'b0;
    step(10);
    dr = ir;
    ld_n = 1'b1;
    step(10);
  endtask : strobe
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmp_flag(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_flag
  task automatic cmp_count(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : cmp_count
  task automatic chk;
    for (int v = 0; v < 2; v++) begin
      cmp("dac a", 16'(dr[v][0]), a[v]);
      cmp("dac b", 16'(dr[v][1]), b[v]);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // ******************************
  // tests
  // ******************************
  initial begin
    logic [23:0] w;
    void'($urandom(32'hC61C));
    step(12);
    rst = 1'b0;
    step(4);
    chk;
    $display("done power on");
    for (int s = 0; s < 4; s++) begin
      w = 24'($urandom);
      w[17:16] = 2'(s);
      w[15:14] = 2'(s);
      frame(w);
      chk;
      strobe;
      chk;
    end
    $display("done address");
    ld_n = 1'b0;
    step(10);
    frame(24'($urandom) | 24'h03C000);
    chk;
    $display("done strobe low");
    for (int p = 0; p < 2; p++) begin
      clr_n = 1'b0;
      pre = p[0];
      // a frame finished under clear must be lost
      i_ddsl_host.send(24'hFFFFFF, 24);
      step(10);
      for (int v = 0; v < 2; v++) begin
        ir[v][0] = p == 0 ? 0 : (v == 0 ? 16'h8000 : 16'h2000);
        ir[v][1] = ir[v][0];
      end
      dr = ir;
      chk;
      clr_n = 1'b1;
      step(10);
      chk;
    end
    $display("done clear");
    hold = 1'b1;
    for (int k = 1; k <= 18; k++) begin
      frame(24'($urandom));
      for (int v = 0; v < 2; v++) cmp_flag("word ready", k < 17, rdy[v]);
      chk;
    end
    for (int v = 0; v < 2; v++) cmp_count("drop count", 1, nd[v]);
    hold = 1'b0;
    foreach (acc[i]) apply(acc[i]);
    step(60);
    dr = ir;
    chk;
    $display("done fill");
    give_verdict;
  end

  initial begin
    #1_000_000;
    n_mismatch++;
    give_verdict;
  end
endmodule : test_ddsl_load_logic

bind ddsl_load_logic ddsl_load_logic_assertions #(.WIDE(WIDE)) i_chk (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_load_strobe_n(i_load_strobe_n), .i_clear_n(i_clear_n),
  .i_preset_mid(i_preset_mid), .i_update_hold(i_update_hold), .o_dac_a_code(o_dac_a_code),
  .o_dac_b_code(o_dac_b_code), .o_word_ready(o_word_ready), .o_word_dropped(o_word_dropped));

`default_nettype wire
